// ---- design/dlcr_regs.sv ----
// Wishbone register bank configuring main and auxiliary digital loops
`timescale 1ns/1ns
module dlcr_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [dlcr_pkg::ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic main_locked_i,
   input wire logic main_ref_low_i,
   input wire logic aux_analog_fb_i,
   input wire logic aux_ref_low_i,
   input wire logic [2:0] aux_loop_rate_i,
   output logic aux_mult_from_main_o,
   output logic [2:0] aux_mult_rate_o,
   output logic [2:0] main_loop_rate_sel_o,
   output logic main_analog_fb_o,
   output logic [1:0] aux_loop_bandwidth_o,
   output logic [3:0] main_loop_bandwidth_o,
   output logic [2:0] aux_loop_damping_o,
   output logic [2:0] main_loop_damping_o,
   output logic [2:0] aux_gain_o,
   output logic [2:0] main_gain_o
);
   import dlcr_pkg::*;

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   // The index decode needs exactly seven bits above the byte lane
   if (ADDR_W != 9) begin : g_addr_check
      $error("address width must be 9");
   end

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic ack_q;
   logic [31:0] dat_q;
   logic [7:0] main_freq_q, aux_bw_q, lock_bw_q, acq_bw_q;
   logic [7:0] aux_damp_q, main_damp_q, aux_gain_q, main_gain_q;

   // Index takes every address bit above the byte lane, so 0x65..0x6D decode, 0x68 aside
   wire word_ok = (adr_i[1:0] == 2'h0);
   wire [6:0] idx = adr_i[ADDR_W-1:2];
   wire req = cyc_i && stb_i;
   // Write lands on the edge where the master sees ack high
   wire wr_go = req && ack_q && we_i && sel_i[0] && word_ok;
   wire [7:0] wd = dat_i[7:0];
   wire hit_freq = wr_go && (idx == MAIN_FREQ_IDX);
   wire hit_aux_bw = wr_go && (idx == AUX_BW_IDX);
   wire hit_lock_bw = wr_go && (idx == MAIN_LOCK_BW_IDX);
   wire hit_acq_bw = wr_go && (idx == MAIN_ACQ_BW_IDX);
   wire hit_aux_damp = wr_go && (idx == AUX_DAMP_IDX);
   wire hit_main_damp = wr_go && (idx == MAIN_DAMP_IDX);
   wire hit_aux_gain = wr_go && (idx == AUX_GAIN_IDX);
   wire hit_main_gain = wr_go && (idx == MAIN_GAIN_IDX);

   logic [7:0] rd_sel;
   always_comb begin
      rd_sel = 8'h00; // Unmapped or misaligned reads answer zero
      if (word_ok) begin
         unique case (idx)
            MAIN_FREQ_IDX: rd_sel = main_freq_q;
            AUX_BW_IDX: rd_sel = aux_bw_q;
            MAIN_LOCK_BW_IDX: rd_sel = lock_bw_q;
            MAIN_ACQ_BW_IDX: rd_sel = acq_bw_q;
            AUX_DAMP_IDX: rd_sel = aux_damp_q;
            MAIN_DAMP_IDX: rd_sel = main_damp_q;
            AUX_GAIN_IDX: rd_sel = aux_gain_q;
            MAIN_GAIN_IDX: rd_sel = main_gain_q;
            default: rd_sel = 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Bus handshake, ack one cycle after the request, then dropped
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req && !ack_q;
         if (req && !ack_q) begin
            dat_q <= {24'h00_0000, rd_sel};
         end
      end
   end
   assign ack_o = ack_q;
   assign dat_o = dat_q;

   // ---------------------------------------------------------------
   // Register storage, masked so unused bits stay zero
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         main_freq_q <= MAIN_FREQ_RST;
         aux_bw_q <= AUX_BW_RST;
         lock_bw_q <= MAIN_LOCK_BW_RST;
         acq_bw_q <= MAIN_ACQ_BW_RST;
         aux_damp_q <= DAMP_RST;
         main_damp_q <= DAMP_RST;
         aux_gain_q <= GAIN_RST;
         main_gain_q <= GAIN_RST;
      end else begin
         if (hit_freq) main_freq_q <= wd & MAIN_FREQ_MASK;
         if (hit_aux_bw) aux_bw_q <= wd & AUX_BW_MASK;
         if (hit_lock_bw) lock_bw_q <= wd & BW4_MASK;
         if (hit_acq_bw) acq_bw_q <= wd & BW4_MASK;
         if (hit_aux_damp) aux_damp_q <= wd & DAMP_MASK;
         if (hit_main_damp) main_damp_q <= wd & DAMP_MASK;
         if (hit_aux_gain) aux_gain_q <= wd & GAIN_MASK;
         if (hit_main_gain) main_gain_q <= wd & GAIN_MASK;
      end
   end

   // ---------------------------------------------------------------
   // Field extraction and applied settings
   // ---------------------------------------------------------------
   wire src_main = main_freq_q[SRC_SEL_BIT];
   wire [1:0] routed = main_freq_q[ROUTED_LSB+1:ROUTED_LSB];
   wire [2:0] main_rate = main_freq_q[2:0];
   wire main_analog = (main_rate == MAIN_RATE_ANALOG);

   logic [2:0] routed_code;
   always_comb begin
      unique case (routed)
         2'h0: routed_code = AUX_RATE_E1_12;
         2'h1: routed_code = AUX_RATE_E1_16;
         2'h2: routed_code = AUX_RATE_DS1_24;
         2'h3: routed_code = AUX_RATE_DS1_16;
      endcase
   end
   // Aux-own rate comes from a register outside this bank
   wire [2:0] mult_rate_d = src_main ? routed_code : aux_loop_rate_i;
   // The applied bandwidth follows lock state with one cycle of latency
   wire [3:0] main_bw_d = main_locked_i ? lock_bw_q[3:0] : acq_bw_q[3:0];

   // Second detector gain choice, shared by both paths
   function automatic logic [2:0] pick_gain(input logic [7:0] g, input logic [7:0] dmp,
                                            input logic analog, input logic low);
      logic [2:0] r;
      r = g[2:0];
      if (g[AUTO_GAIN_BIT] && analog) begin
         r = low ? dmp[LOWGAIN_LSB+2:LOWGAIN_LSB] : g[HIGAIN_LSB+2:HIGAIN_LSB];
      end
      return r;
   endfunction

   wire [2:0] aux_gain_d = pick_gain(aux_gain_q, aux_damp_q, aux_analog_fb_i,
                                     aux_ref_low_i);
   wire [2:0] main_gain_d = pick_gain(main_gain_q, main_damp_q, main_analog,
                                      main_ref_low_i);

   // ---------------------------------------------------------------
   // Registered outputs to the loops
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aux_mult_from_main_o <= 1'b0;
         aux_mult_rate_o <= 3'h0;
         main_loop_rate_sel_o <= 3'h0;
         main_analog_fb_o <= 1'b0;
         aux_loop_bandwidth_o <= 2'h0;
         main_loop_bandwidth_o <= 4'h0;
         aux_loop_damping_o <= 3'h0;
         main_loop_damping_o <= 3'h0;
         aux_gain_o <= 3'h0;
         main_gain_o <= 3'h0;
      end else begin
         aux_mult_from_main_o <= src_main;
         aux_mult_rate_o <= mult_rate_d;
         main_loop_rate_sel_o <= main_rate;
         main_analog_fb_o <= main_analog;
         aux_loop_bandwidth_o <= aux_bw_q[1:0];
         main_loop_bandwidth_o <= main_bw_d;
         aux_loop_damping_o <= aux_damp_q[2:0];
         main_loop_damping_o <= main_damp_q[2:0];
         aux_gain_o <= aux_gain_d;
         main_gain_o <= main_gain_d;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_write_main_freq;
      hit_freq ##1 1'b1;
   endsequence

   a_src_follows_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_freq |-> ##2 aux_mult_from_main_o == $past(wd[SRC_SEL_BIT], 2))
      else $error("source select did not follow bit 6");
   a_routed_rate_used: assert property (@(posedge clk_i) disable iff (rst_i)
      src_main && routed == 2'h1 |=> aux_mult_rate_o == AUX_RATE_E1_16)
      else $error("routed rate not applied");
   a_routed_e1_code: assert property (@(posedge clk_i) disable iff (rst_i)
      src_main && routed == 2'h0 |=> aux_mult_rate_o == AUX_RATE_E1_12)
      else $error("routed code 00 wrong rate");
   a_aux_own_rate: assert property (@(posedge clk_i) disable iff (rst_i)
      !src_main |=> aux_mult_rate_o == $past(aux_loop_rate_i))
      else $error("aux rate not passed through");
   a_analog_fb_code: assert property (@(posedge clk_i) disable iff (rst_i)
      s_write_main_freq |=> main_analog_fb_o == ($past(wd[2:0], 2) == 3'h1))
      else $error("feedback mode mismatch");
   a_aux_bw_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      aux_bw_q[7:2] == 6'h00)
      else $error("aux bandwidth unused bits set");
   a_bw_locked_pick: assert property (@(posedge clk_i) disable iff (rst_i)
      main_locked_i |=> main_loop_bandwidth_o == $past(lock_bw_q[3:0]))
      else $error("locked bandwidth not applied");
   a_bw_acq_pick: assert property (@(posedge clk_i) disable iff (rst_i)
      !main_locked_i |=> main_loop_bandwidth_o == $past(acq_bw_q[3:0]))
      else $error("acquire bandwidth not applied");
   a_damp_reset_val: assert property (@(posedge clk_i)
      $fell(rst_i) |-> main_damp_q == DAMP_RST && aux_damp_q == DAMP_RST)
      else $error("damping reset value wrong");
   a_aux_low_gain: assert property (@(posedge clk_i) disable iff (rst_i)
      aux_gain_q[7] && aux_analog_fb_i && aux_ref_low_i
      |=> aux_gain_o == $past(aux_damp_q[6:4]))
      else $error("aux low-frequency gain not used");
   a_main_low_gain: assert property (@(posedge clk_i) disable iff (rst_i)
      main_gain_q[7] && main_analog && main_ref_low_i
      |=> main_gain_o == $past(main_damp_q[6:4]))
      else $error("main low-frequency gain not used");
   a_auto_off_digital: assert property (@(posedge clk_i) disable iff (rst_i)
      !main_gain_q[7] |=> main_gain_o == $past(main_gain_q[2:0]))
      else $error("digital gain not used with auto off");
   a_high_gain_pick: assert property (@(posedge clk_i) disable iff (rst_i)
      aux_gain_q[7] && aux_analog_fb_i && !aux_ref_low_i
      |=> aux_gain_o == $past(aux_gain_q[6:4]))
      else $error("high-frequency gain not used");
   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_q |=> !ack_q)
      else $error("ack held too long");
   a_read_back: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !ack_q && !we_i && word_ok && idx == MAIN_GAIN_IDX
      |=> dat_o == {24'h00_0000, $past(main_gain_q)})
      else $error("read data mismatch");

   // ---------------------------------------------------------------
   // Applied settings follow their registers
   // ---------------------------------------------------------------
   a_src_out: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> aux_mult_from_main_o == $past(main_freq_q[SRC_SEL_BIT]))
      else $error("source select output stale");
   a_main_rate_out: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> main_loop_rate_sel_o == $past(main_freq_q[2:0]))
      else $error("main rate output stale");
   a_analog_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> main_analog_fb_o == ($past(main_freq_q[2:0]) == MAIN_RATE_ANALOG))
      else $error("analog feedback flag wrong");
   a_aux_bw_out: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> aux_loop_bandwidth_o == $past(aux_bw_q[1:0]))
      else $error("aux bandwidth output stale");
   a_aux_damp_out: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> aux_loop_damping_o == $past(aux_damp_q[2:0]))
      else $error("aux damping output stale");
   a_main_damp_out: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> main_loop_damping_o == $past(main_damp_q[2:0]))
      else $error("main damping output stale");
   a_routed_ds1_24: assert property (@(posedge clk_i) disable iff (rst_i)
      src_main && routed == 2'h2 |=> aux_mult_rate_o == AUX_RATE_DS1_24)
      else $error("routed code 10 wrong rate");
   a_routed_ds1_16: assert property (@(posedge clk_i) disable iff (rst_i)
      src_main && routed == 2'h3 |=> aux_mult_rate_o == AUX_RATE_DS1_16)
      else $error("routed code 11 wrong rate");
   a_main_high_gain: assert property (@(posedge clk_i) disable iff (rst_i)
      main_gain_q[7] && main_analog && !main_ref_low_i
      |=> main_gain_o == $past(main_gain_q[6:4]))
      else $error("main high-frequency gain not used");
   a_aux_auto_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !aux_gain_q[7] |=> aux_gain_o == $past(aux_gain_q[2:0]))
      else $error("aux digital gain not used with auto off");
   a_aux_digital_fb: assert property (@(posedge clk_i) disable iff (rst_i)
      aux_gain_q[7] && !aux_analog_fb_i |=> aux_gain_o == $past(aux_gain_q[2:0]))
      else $error("aux digital feedback gain wrong");
   a_main_digital_fb: assert property (@(posedge clk_i) disable iff (rst_i)
      main_gain_q[7] && !main_analog |=> main_gain_o == $past(main_gain_q[2:0]))
      else $error("main digital feedback gain wrong");

   // ---------------------------------------------------------------
   // Writes land masked, and only when addressed
   // ---------------------------------------------------------------
   a_freq_write: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_freq |=> main_freq_q == $past(wd & MAIN_FREQ_MASK))
      else $error("frequency write lost");
   a_aux_bw_write: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_aux_bw |=> aux_bw_q == $past(wd & AUX_BW_MASK))
      else $error("aux bandwidth write lost");
   a_lock_bw_write: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_lock_bw |=> lock_bw_q == $past(wd & BW4_MASK))
      else $error("locked bandwidth write lost");
   a_acq_bw_write: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_acq_bw |=> acq_bw_q == $past(wd & BW4_MASK))
      else $error("acquire bandwidth write lost");
   a_aux_damp_write: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_aux_damp |=> aux_damp_q == $past(wd & DAMP_MASK))
      else $error("aux damping write lost");
   a_main_damp_write: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_main_damp |=> main_damp_q == $past(wd & DAMP_MASK))
      else $error("main damping write lost");
   a_aux_gain_write: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_aux_gain |=> aux_gain_q == $past(wd & GAIN_MASK))
      else $error("aux gain write lost");
   a_main_gain_write: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_main_gain |=> main_gain_q == $past(wd & GAIN_MASK))
      else $error("main gain write lost");
   a_freq_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !hit_freq |=> $stable(main_freq_q))
      else $error("frequency register changed unaddressed");
   a_gain_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !hit_aux_gain && !hit_main_gain |=> $stable(aux_gain_q) && $stable(main_gain_q))
      else $error("gain register changed unaddressed");
   a_sel_guard: assert property (@(posedge clk_i) disable iff (rst_i)
      req && ack_q && we_i && !sel_i[0] |=> $stable(aux_bw_q))
      else $error("write without byte select landed");

   // ---------------------------------------------------------------
   // Unused bits and reset values
   // ---------------------------------------------------------------
   a_freq_unused: assert property (@(posedge clk_i) disable iff (rst_i)
      main_freq_q[7] == 1'b0 && main_freq_q[3] == 1'b0)
      else $error("frequency unused bits set");
   a_bw_unused: assert property (@(posedge clk_i) disable iff (rst_i)
      lock_bw_q[7:4] == 4'h0 && acq_bw_q[7:4] == 4'h0)
      else $error("bandwidth unused bits set");
   a_damp_unused: assert property (@(posedge clk_i) disable iff (rst_i)
      aux_damp_q[7] == 1'b0 && aux_damp_q[3] == 1'b0 && main_damp_q[7] == 1'b0)
      else $error("damping unused bits set");
   a_gain_unused: assert property (@(posedge clk_i) disable iff (rst_i)
      aux_gain_q[3] == 1'b0 && main_gain_q[3] == 1'b0)
      else $error("gain unused bits set");
   a_reset_gain: assert property (@(posedge clk_i)
      $fell(rst_i) |-> aux_gain_q == GAIN_RST && main_gain_q == GAIN_RST)
      else $error("gain reset value wrong");
   a_reset_bw: assert property (@(posedge clk_i)
      $fell(rst_i) |-> lock_bw_q == MAIN_LOCK_BW_RST && acq_bw_q == MAIN_ACQ_BW_RST
      && aux_bw_q == AUX_BW_RST)
      else $error("bandwidth reset value wrong");
   a_reset_freq: assert property (@(posedge clk_i)
      $fell(rst_i) |-> main_freq_q == MAIN_FREQ_RST)
      else $error("frequency reset value wrong");
   a_reset_ack: assert property (@(posedge clk_i)
      $fell(rst_i) |-> !ack_q && dat_q == 32'h0000_0000)
      else $error("bus outputs not cleared by reset");

   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !ack_q |=> ack_q)
      else $error("request not answered next cycle");
   a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_q |-> $past(req))
      else $error("ack without request");
   a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !ack_q && !we_i && idx == 7'h68 |=> dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_dat_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      dat_o[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   a_read_freq: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !ack_q && !we_i && word_ok && idx == MAIN_FREQ_IDX
      |=> dat_o == {24'h00_0000, $past(main_freq_q)})
      else $error("frequency read data mismatch");
endmodule

// ---- design/dlcr_pkg.sv ----
// Package of offsets, field positions and reset values for the loop configuration bank
package dlcr_pkg;
   // ---------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [6:0] MAIN_FREQ_IDX = 7'h65;
   localparam logic [6:0] AUX_BW_IDX = 7'h66;
   localparam logic [6:0] MAIN_LOCK_BW_IDX = 7'h67;
   localparam logic [6:0] MAIN_ACQ_BW_IDX = 7'h69;
   localparam logic [6:0] AUX_DAMP_IDX = 7'h6A;
   localparam logic [6:0] MAIN_DAMP_IDX = 7'h6B;
   localparam logic [6:0] AUX_GAIN_IDX = 7'h6C;
   localparam logic [6:0] MAIN_GAIN_IDX = 7'h6D;
   // ---------------------------------------------------------------
   // Writable bit masks, unused bits read zero
   // ---------------------------------------------------------------
   localparam logic [7:0] MAIN_FREQ_MASK = 8'h77;
   localparam logic [7:0] AUX_BW_MASK = 8'h03;
   localparam logic [7:0] BW4_MASK = 8'h0F;
   localparam logic [7:0] DAMP_MASK = 8'h77;
   localparam logic [7:0] GAIN_MASK = 8'hF7;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MAIN_FREQ_RST = 8'h00;
   localparam logic [7:0] AUX_BW_RST = 8'h00;
   localparam logic [7:0] MAIN_LOCK_BW_RST = 8'h0B;
   localparam logic [7:0] MAIN_ACQ_BW_RST = 8'h00;
   localparam logic [7:0] DAMP_RST = 8'h13;
   localparam logic [7:0] GAIN_RST = 8'hC2;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SRC_SEL_BIT = 6;
   localparam int ROUTED_LSB = 4;
   localparam int LOWGAIN_LSB = 4;
   localparam int HIGAIN_LSB = 4;
   localparam int AUTO_GAIN_BIT = 7;
   // ---------------------------------------------------------------
   // Codes
   // ---------------------------------------------------------------
   localparam logic [2:0] MAIN_RATE_ANALOG = 3'h1;
   // Aux-loop rate codes for the four routed multiplier rates
   localparam logic [2:0] AUX_RATE_E1_12 = 3'h2;
   localparam logic [2:0] AUX_RATE_E1_16 = 3'h3;
   localparam logic [2:0] AUX_RATE_DS1_24 = 3'h4;
   localparam logic [2:0] AUX_RATE_DS1_16 = 3'h5;
   localparam int ADDR_W = 9;
endpackage

// ---- tb/dlcr_regs_bench.sv ----
// Self-checking bench for the loop configuration register bank
`timescale 1ns/1ns
module dlcr_regs_bench;
   import dlcr_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [ADDR_W-1:0] adr_i = '0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd_v;
   logic ack_o, main_locked_i = 1'b0, main_ref_low_i = 1'b0;
   logic aux_analog_fb_i = 1'b0, aux_ref_low_i = 1'b0;
   logic [2:0] aux_loop_rate_i = 3'h6;
   logic aux_mult_from_main_o, main_analog_fb_o;
   logic [2:0] aux_mult_rate_o, main_loop_rate_sel_o, aux_loop_damping_o, main_loop_damping_o;
   logic [2:0] aux_gain_o, main_gain_o;
   logic [1:0] aux_loop_bandwidth_o;
   logic [3:0] main_loop_bandwidth_o;
   int n_mismatch = 0, cmp_count = 0, cyc_cnt = 0;
   logic [6:0] idx_tab [8] = '{MAIN_FREQ_IDX, AUX_BW_IDX, MAIN_LOCK_BW_IDX, MAIN_ACQ_BW_IDX,
      AUX_DAMP_IDX, MAIN_DAMP_IDX, AUX_GAIN_IDX, MAIN_GAIN_IDX};
   logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h0B, 8'h00, 8'h13, 8'h13, 8'hC2, 8'hC2};
   logic [7:0] msk_tab [8] = '{8'h77, 8'h03, 8'h0F, 8'h0F, 8'h77, 8'h77, 8'hF7, 8'hF7};
   // ---------------------------------------------------------------
   // Clock, timeout, design
   // ---------------------------------------------------------------
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // Whole run is a few hundred cycles, so this ceiling only trips on a hang
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000) begin
         n_mismatch = n_mismatch + 1;
         end_sim();
      end
   end
   dlcr_regs u_dlcr_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .main_locked_i(main_locked_i), .main_ref_low_i(main_ref_low_i),
      .aux_analog_fb_i(aux_analog_fb_i), .aux_ref_low_i(aux_ref_low_i),
      .aux_loop_rate_i(aux_loop_rate_i), .aux_mult_from_main_o(aux_mult_from_main_o),
      .aux_mult_rate_o(aux_mult_rate_o), .main_loop_rate_sel_o(main_loop_rate_sel_o),
      .main_analog_fb_o(main_analog_fb_o), .aux_loop_bandwidth_o(aux_loop_bandwidth_o),
      .main_loop_bandwidth_o(main_loop_bandwidth_o), .aux_loop_damping_o(aux_loop_damping_o),
      .main_loop_damping_o(main_loop_damping_o), .aux_gain_o(aux_gain_o),
      .main_gain_o(main_gain_o));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, then release
   task automatic bus(input logic [6:0] idx, input logic we, input logic [7:0] wd,
         input logic [3:0] sel, output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= {idx, 2'b00};
      sel_i <= sel;
      dat_i <= {24'h0, wd};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 100);
      rdat = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (n >= 100) begin
         n_mismatch = n_mismatch + 1;
         end_sim();
      end
   endtask
   task automatic wr(input logic [6:0] idx, input logic [7:0] wd);
      bus(idx, 1'b1, wd, 4'h1, rd_v);
   endtask
   task automatic rd(input logic [6:0] idx, output logic [31:0] v);
      bus(idx, 1'b0, 8'h00, 4'hF, v);
   endtask
   // Derived outputs lag their cause by one clock; sampled values predate this edge
   task automatic settle();
      repeat (3) @(posedge clk_i);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] v;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      check({29'h0, main_loop_damping_o}, 32'h3);
      check({29'h0, main_gain_o}, 32'h2);
      for (int i = 0; i < 8; i++) begin
         rd(idx_tab[i], v);
         check(v, {24'h0, rst_tab[i]});
      end
      rd(7'h68, v);
      check(v, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         wr(idx_tab[i], 8'hFF);
         rd(idx_tab[i], v);
         check(v, {24'h0, msk_tab[i]});
      end
      bus(AUX_BW_IDX, 1'b1, 8'h00, 4'hE, rd_v);
      rd(AUX_BW_IDX, v);
      check(v, 32'h3);
      wr(7'h68, 8'hFF);
      rd(7'h68, v);
      check(v, 32'h0);
      $display("test read write masks done");
      for (int c = 0; c < 4; c++) begin
         wr(MAIN_FREQ_IDX, {2'b01, 2'(c), 4'h0});
         settle();
         check({31'h0, aux_mult_from_main_o}, 32'h1);
         check({29'h0, aux_mult_rate_o}, 32'(c + 2));
      end
      wr(MAIN_FREQ_IDX, 8'h30);
      settle();
      check({31'h0, aux_mult_from_main_o}, 32'h0);
      check({29'h0, aux_mult_rate_o}, 32'h6);
      for (int r = 0; r < 6; r++) begin
         wr(MAIN_FREQ_IDX, 8'(r));
         settle();
         check({29'h0, main_loop_rate_sel_o}, 32'(r));
         check({31'h0, main_analog_fb_o}, {31'h0, r == 1});
      end
      $display("test rate routing done");
      wr(MAIN_LOCK_BW_IDX, 8'h08);
      wr(MAIN_ACQ_BW_IDX, 8'h0C);
      wr(AUX_BW_IDX, 8'h02);
      wr(AUX_DAMP_IDX, 8'h45);
      wr(MAIN_DAMP_IDX, 8'h53);
      @(posedge clk_i);
      main_locked_i <= 1'b1;
      settle();
      check({28'h0, main_loop_bandwidth_o}, 32'h8);
      check({30'h0, aux_loop_bandwidth_o}, 32'h2);
      check({29'h0, aux_loop_damping_o}, 32'h5);
      check({29'h0, main_loop_damping_o}, 32'h3);
      main_locked_i <= 1'b0;
      settle();
      check({28'h0, main_loop_bandwidth_o}, 32'hC);
      $display("test bandwidth damping done");
      // Main path: damping holds low-ref gain 5, gain reg high 6 digital 1
      wr(MAIN_GAIN_IDX, 8'hE1);
      wr(MAIN_FREQ_IDX, 8'h01);
      @(posedge clk_i);
      main_ref_low_i <= 1'b1;
      settle();
      check({29'h0, main_gain_o}, 32'h5);
      main_ref_low_i <= 1'b0;
      settle();
      check({29'h0, main_gain_o}, 32'h6);
      wr(MAIN_GAIN_IDX, 8'h61);
      settle();
      check({29'h0, main_gain_o}, 32'h1);
      wr(MAIN_GAIN_IDX, 8'hE1);
      wr(MAIN_FREQ_IDX, 8'h00);
      settle();
      check({29'h0, main_gain_o}, 32'h1);
      // Aux path: low-ref gain 4, high 5, digital 7
      wr(AUX_GAIN_IDX, 8'hD7);
      @(posedge clk_i);
      aux_analog_fb_i <= 1'b1;
      aux_ref_low_i <= 1'b1;
      settle();
      check({29'h0, aux_gain_o}, 32'h4);
      aux_ref_low_i <= 1'b0;
      settle();
      check({29'h0, aux_gain_o}, 32'h5);
      wr(AUX_GAIN_IDX, 8'h57);
      settle();
      check({29'h0, aux_gain_o}, 32'h7);
      wr(AUX_GAIN_IDX, 8'hD7);
      @(posedge clk_i);
      aux_analog_fb_i <= 1'b0;
      settle();
      check({29'h0, aux_gain_o}, 32'h7);
      $display("test detector gain done");
      end_sim();
   end
endmodule
